/* File: gdsc_pkg.sv */
// Constants, types and carriers shared by the gate drive state control.
// How it works
// R1: Each gate output follows its phase command.
// R2: Undriven phase command reads low, driver off.
// R3: Fault, long enable low or sleep force off.
// R4: Gate bias checked only while driving.
// R5: Filtered gate bias low latches fault, blocks turn-on.
// R6: Gate bias fault latched until enable toggles.
// R7: Check enable bit disables gate bias lockout.
// R8: Enable low with sleep request enters sleep.
// R9: Standby keeps logic, link, monitors; amps configurable.
// R10: Overtemperature kills drivers; link off 5 ms after the fault message is sent.
// R11: Supply cutoff switches off every block; in sleep the code stays in sleep and keeps the wake latch on.
// R12: Power status set at reset, cutoff, wake.
// R13: Enable low over 1 ms enters standby.
// R14: Enable rise clears only ceased latched faults.
// R15: Latched fault keeps outputs forced low.
package gdsc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 10;
    localparam int DE_LOW_TIME_US = 1000;
    localparam int DE_LOW_CYCLES = DE_LOW_TIME_US * CLK_MHZ;
    localparam int LINK_OFF_TIME_US = 5000;
    localparam int LINK_OFF_CYCLES = LINK_OFF_TIME_US * CLK_MHZ;
    localparam int GB_FILTER_TIME_NS = 10000;
    localparam int GB_FILTER_CYCLES = (GB_FILTER_TIME_NS * CLK_MHZ + 999)
        / 1000;
    localparam int TMR_W = 16;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_PWR_CLR = 8'h10;

    localparam int CTRL_W = 3;
    localparam int CTRL_SLEEP_REQ = 0;
    localparam int CTRL_GB_CHECK = 1;
    localparam int CTRL_AMP_OFF = 2;
    localparam logic [2:0] CTRL_RESET = 3'h2;

    localparam int FLT_N = 6;
    localparam int FLT_OT = 0;
    localparam int FLT_LOW = 1;
    localparam int FLT_HIGH = 2;
    localparam int FLT_REG_UV = 3;
    localparam int FLT_GB = 4;
    localparam int FLT_OC = 5;

    localparam int ST_FAULT_ANY = 6;
    localparam int ST_STATE_LSB = 8;
    localparam int ST_PWR_LSB = 10;
    localparam int ST_LINK_OFF = 13;

    localparam int IRQ_N = 3;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_PWR = 1;
    localparam int IRQ_STBY = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam logic [2:0] PWR_NORMAL = 3'h0;
    localparam logic [2:0] PWR_POR = 3'h1;
    localparam logic [2:0] PWR_CUTOFF = 3'h2;
    localparam logic [2:0] PWR_WAKE = 3'h3;
    localparam logic [2:0] PWR_OT = 3'h5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        st_operating,
        st_standby,
        st_sleep,
        st_cutoff
    } gdsc_state_t;

    typedef struct packed {
        logic overcurrent;
        logic reg_uv;
        logic supply_high;
        logic supply_low;
        logic supply_cutoff;
        logic overtemp;
    } gdsc_monitor_t;

    typedef struct packed {
        logic wake_latch;
        logic monitor;
        logic amp;
        logic link;
        logic bias_reg;
        logic logic_reg;
    } gdsc_blocks_t;

endpackage

/* File: gdsc_sync.sv */
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/10ps
module gdsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // Both stages reset low so a floating command reads as off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= '0; // R2
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: gdsc_timer.sv */
// Saturating run-time counter with a done level at the limit.
`timescale 1ns/10ps
module gdsc_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] count;

    assign done = run && (count == limit);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= '0;
        else if (!run)
            count <= '0;
        else if (!done)
            count <= count + 1'b1;
    end
endmodule

/* File: gdsc_top.sv */
// Gate drive supervisory state control with APB registers.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module gdsc_top
    import gdsc_pkg::*;
#(
    parameter int DE_LOW_CYCLES_P = DE_LOW_CYCLES,
    parameter int LINK_OFF_CYCLES_P = LINK_OFF_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host pins
    input wire logic [5:0] phase_cmd,
    input wire logic drive_enable,
    input wire logic wake_pin,
    output logic fault_pin_o,
    output logic fault_pin_oe,
    // Analog monitors
    input wire logic [5:0] gate_bias_low,
    input wire gdsc_monitor_t mon_in,
    // Link logic, same clock
    input wire logic fault_msg_sent,
    // Gate drivers, block enables and interrupt
    output logic [2:0] gate_hi,
    output logic [2:0] gate_lo,
    output gdsc_blocks_t block_en,
    output logic irq
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [19:0] raw_in;
    logic [19:0] sync_in;
    logic [5:0] cmd_s;
    logic de_s;
    logic wake_s;
    logic [5:0] gb_low_s;
    gdsc_monitor_t mon_s;

    assign raw_in = {phase_cmd, drive_enable, wake_pin, gate_bias_low,
        mon_in};

    gdsc_sync #(.W(20)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_in),
        .q(sync_in)
    );

    assign cmd_s = sync_in[19:14];
    assign de_s = sync_in[13];
    assign wake_s = sync_in[12];
    assign gb_low_s = sync_in[11:6];
    assign mon_s = gdsc_monitor_t'(sync_in[5:0]);

    // ****************************************************************
    // State registers
    // ****************************************************************
    gdsc_state_t state;
    gdsc_state_t next_state;
    logic de_q;
    logic wake_q;
    logic [5:0] gate_q;
    logic [FLT_N-1:0] latch;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_mask;
    logic [2:0] pstat;
    logic ot_msg;
    logic [31:0] rd_q;

    // ****************************************************************
    // Timers
    // ****************************************************************
    logic de_long_low;
    logic gb_active;
    logic gb_done;
    logic link_off;

    gdsc_timer #(.W(TMR_W)) u_de_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(!de_s),
        .limit(TMR_W'(DE_LOW_CYCLES_P)),
        .done(de_long_low)
    );

    // The filter restarts whenever driving stops, so a dip seen
    // between pulses never adds up across them.
    assign gb_active = ctrl[CTRL_GB_CHECK] && block_en.monitor
        && |(gate_q & gb_low_s); // R4 R7

    gdsc_timer #(.W(TMR_W)) u_gb_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(gb_active),
        .limit(TMR_W'(GB_FILTER_CYCLES)),
        .done(gb_done)
    );

    gdsc_timer #(.W(TMR_W)) u_link_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .run(ot_msg && latch[FLT_OT]),
        .limit(TMR_W'(LINK_OFF_CYCLES_P)),
        .done(link_off)
    ); // R10

    // ****************************************************************
    // Fault latches
    // ****************************************************************
    logic de_rise;
    logic mon_on;
    logic [FLT_N-1:0] cond;
    logic [FLT_N-1:0] flt_set;
    logic [FLT_N-1:0] flt_clr;
    logic [FLT_N-1:0] next_latch;
    logic fault_now;
    logic fault_any;
    logic flt_evt;

    assign de_rise = de_s && !de_q;
    assign mon_on = (state == st_operating) || (state == st_standby);
    assign cond = {mon_s.overcurrent, gb_done, mon_s.reg_uv,
        mon_s.supply_high, mon_s.supply_low, mon_s.overtemp};
    assign flt_set = cond & {FLT_N{mon_on}}; // R5
    assign flt_clr = {FLT_N{de_rise}} & ~cond; // R6 R14
    assign next_latch = (latch & ~flt_clr) | flt_set;
    assign fault_now = mon_on && |cond;
    assign fault_any = fault_now || |latch; // R15
    assign flt_evt = |(flt_set & ~latch);

    // ****************************************************************
    // Operating state
    // ****************************************************************
    logic wake_evt;
    logic cut_evt;
    logic stby_evt;
    logic ot_evt;
    logic pwr_evt;

    assign wake_evt = (state == st_sleep) && wake_s && !wake_q;
    assign cut_evt = (state != st_cutoff) && mon_s.supply_cutoff;
    assign ot_evt = flt_set[FLT_OT] && !latch[FLT_OT];
    assign pwr_evt = wake_evt || cut_evt || ot_evt;
    assign stby_evt = (next_state == st_standby)
        && (state != st_standby);

    // Sleep is taken even with a fault standing, so a host fed from
    // the logic regulator can still shut the part down.
    always_comb
    begin
        next_state = state;
        unique case (state)
            st_sleep:
                if (wake_evt)
                    next_state = st_standby;
            st_cutoff:
                if (!mon_s.supply_cutoff)
                    next_state = st_standby;
            st_operating, st_standby:
                if (mon_s.supply_cutoff)
                    next_state = st_cutoff; // R11
                else if (!de_s && ctrl[CTRL_SLEEP_REQ])
                    next_state = st_sleep; // R8
                else if (de_long_low)
                    next_state = st_standby; // R13
                else if (de_s)
                    next_state = st_operating;
        endcase
    end

    // ****************************************************************
    // Gate outputs and block enables
    // ****************************************************************
    logic force_off;
    logic [5:0] next_gate;
    gdsc_blocks_t next_blk;
    logic bias_fault;

    assign force_off = fault_any || de_long_low
        || (state == st_sleep) || (state == st_cutoff); // R3 R15
    assign next_gate = force_off ? 6'h00 : cmd_s; // R1
    assign gate_hi = gate_q[2:0];
    assign gate_lo = gate_q[5:3];
    assign bias_fault = latch[FLT_OT] || latch[FLT_LOW]
        || latch[FLT_HIGH] || latch[FLT_REG_UV];

    always_comb
    begin
        next_blk = '0;
        unique case (state)
            st_operating:
            begin
                next_blk.logic_reg = !link_off;
                next_blk.bias_reg = !bias_fault; // R10
                next_blk.link = !link_off; // R10
                next_blk.amp = !latch[FLT_OT];
                next_blk.monitor = 1'b1;
            end
            st_standby:
            begin
                next_blk.logic_reg = !link_off; // R9
                next_blk.link = !link_off;
                next_blk.amp = !ctrl[CTRL_AMP_OFF] && !latch[FLT_OT];
                next_blk.monitor = 1'b1;
            end
            st_sleep:
                next_blk.wake_latch = 1'b1; // R8
            st_cutoff:
                next_blk = '0; // R11
        endcase
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_status;
    logic hit_istat;
    logic hit_imask;
    logic hit_pclr;
    logic mapped;
    logic cfg_lost;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign hit_ctrl = paddr == ADDR_CTRL;
    assign hit_status = paddr == ADDR_STATUS;
    assign hit_istat = paddr == ADDR_IRQ_STAT;
    assign hit_imask = paddr == ADDR_IRQ_MASK;
    assign hit_pclr = paddr == ADDR_PWR_CLR;
    assign mapped = hit_ctrl || hit_status || hit_istat || hit_imask
        || hit_pclr;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rd_q;
    assign cfg_lost = wake_evt || cut_evt; // R12

    always_comb
    begin
        status_word = '0;
        status_word[FLT_N-1:0] = latch;
        status_word[ST_FAULT_ANY] = fault_any; // R5
        status_word[ST_STATE_LSB+:2] = state;
        status_word[ST_PWR_LSB+:3] = pstat;
        status_word[ST_LINK_OFF] = link_off;
    end

    assign rd_mux = hit_ctrl ? {29'h0, ctrl}
        : hit_status ? status_word
        : hit_istat ? {29'h0, irq_stat}
        : hit_imask ? {29'h0, irq_mask}
        : 32'h0;

    assign irq = |(irq_stat & irq_mask);
    assign fault_pin_o = 1'b0;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= st_standby;
            de_q <= 1'b0;
            wake_q <= 1'b0;
            gate_q <= 6'h00;
            latch <= '0;
            ot_msg <= 1'b0;
            block_en <= '0;
            fault_pin_oe <= 1'b0;
            rd_q <= 32'h0;
        end
        else
        begin
            state <= next_state;
            de_q <= de_s;
            wake_q <= wake_s;
            gate_q <= next_gate;
            latch <= next_latch;
            ot_msg <= latch[FLT_OT] && (ot_msg || fault_msg_sent);
            block_en <= next_blk;
            fault_pin_oe <= fault_any; // R5
            rd_q <= setup ? rd_mux : rd_q;
        end
    end

    // The control register is lost on wake and on cutoff; the host must
    // send it again, so a stale sleep request cannot re-trigger.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
            irq_stat <= '0;
            pstat <= PWR_POR; // R12
        end
        else
        begin
            if (cfg_lost)
                ctrl <= CTRL_RESET;
            else if (wr_en && hit_ctrl)
                ctrl <= pwdata[CTRL_W-1:0];
            if (wr_en && hit_imask)
                irq_mask <= pwdata[IRQ_N-1:0];
            irq_stat <= (irq_stat
                & ~((wr_en && hit_istat) ? pwdata[IRQ_N-1:0] : 3'h0))
                | {stby_evt, pwr_evt, flt_evt};
            if (wake_evt)
                pstat <= PWR_WAKE; // R12
            else if (cut_evt)
                pstat <= PWR_CUTOFF; // R12
            else if (ot_evt)
                pstat <= PWR_OT;
            else if (wr_en && hit_pclr)
                pstat <= PWR_NORMAL;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    force_low_a: assert property (force_off |=> gate_q == 6'h00) // R3
        else $error("Gate output on while forced off.");

    follow_cmd_a: assert property (!force_off |=> gate_q == $past(cmd_s))
        else $error("Gate output does not follow command."); // R1

    latch_hold_a: assert property (latch[FLT_GB] && !de_rise
        |=> latch[FLT_GB] && force_off) // R6
        else $error("Gate bias fault dropped without enable toggle.");

    clear_ceased_a: assert property (latch[FLT_OC] && de_rise
        && !cond[FLT_OC] |=> !latch[FLT_OC]) // R14
        else $error("Ceased fault not cleared by enable rise.");

    gb_driving_a: assert property ($rose(latch[FLT_GB])
        |-> $past(gb_active, 2) && $past(ctrl[CTRL_GB_CHECK], 2)) // R4
        else $error("Gate bias fault without driving or check.");

    sleep_entry_a: assert property (mon_on && !de_s
        && ctrl[CTRL_SLEEP_REQ] && !mon_s.supply_cutoff
        |=> state == st_sleep ##1 block_en.wake_latch
        && !block_en.link && !block_en.logic_reg) // R8
        else $error("Sleep not entered with enable low.");

    standby_blocks_a: assert property (state == st_standby && !link_off
        |=> block_en.link && block_en.logic_reg && block_en.monitor
        && !block_en.bias_reg) // R9
        else $error("Standby block enables wrong.");

    cutoff_off_a: assert property (cut_evt |=> ##1 block_en == '0
        && pstat == PWR_CUTOFF) // R11
        else $error("Cutoff did not switch blocks off.");

    wake_pstat_a: assert property (wake_evt |=> pstat == PWR_WAKE
        && ctrl == CTRL_RESET) // R12
        else $error("Wake did not set power status.");

    standby_entry_a: assert property (!de_s && de_long_low
        && !ctrl[CTRL_SLEEP_REQ] && mon_on && !mon_s.supply_cutoff
        |=> state == st_standby) // R13
        else $error("Standby not entered after long enable low.");

    ot_link_a: assert property (link_off
        |=> !block_en.link && !block_en.logic_reg) // R10
        else $error("Link still on after the link-off time.");

    sleep_c: cover property (state == st_standby ##1 state == st_sleep);
    wake_c: cover property (wake_evt);
    gb_fault_c: cover property ($rose(latch[FLT_GB]));
    irq_c: cover property ($rose(irq));

endmodule

/* File: gdsc_host.sv */
// Host controller model driving the phase commands and the enable pin.
`timescale 1ns/10ps
module gdsc_host (
    // Bench requests
    input wire logic [5:0] want_phase,
    input wire logic want_float,
    input wire logic want_enable,
    // Device pins
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    output logic [5:0] phase_cmd,
    output logic drive_enable,
    output logic fault_n
);
    // ****************************************************************
    // Pin levels
    // ****************************************************************
    // A floated command line settles low through the pad pull-down.
    assign phase_cmd = want_float ? 6'h00 : want_phase;
    assign drive_enable = want_enable;
    // The open-drain fault line idles high through its pull-up.
    assign fault_n = fault_pin_oe ? fault_pin_o : 1'b1;
endmodule

/* File: tb_gdsc_top.sv */
// Self-checking bench for the gate drive state control.
`timescale 1ns/10ps
module tb_gdsc_top import gdsc_pkg::*;;
    localparam int DE_LOW = 20;
    localparam int LINK_OFF = 30;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] want_phase = 6'h00;
    logic want_float = 1'b0;
    logic want_enable = 1'b0;
    logic wake_pin = 1'b0;
    logic [5:0] gate_bias_low = 6'h00;
    gdsc_monitor_t mon_in = '0;
    logic fault_msg_sent = 1'b0;
    logic [31:0] prdata, rd, lf;
    logic [5:0] phase_cmd, ph;
    logic [2:0] gate_hi, gate_lo;
    logic pready, pslverr, err, drive_enable, fault_pin_o, fault_pin_oe;
    logic fault_n, irq;
    gdsc_blocks_t block_en;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    gdsc_top #(.DE_LOW_CYCLES_P(DE_LOW), .LINK_OFF_CYCLES_P(LINK_OFF)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_cmd(phase_cmd), .drive_enable(drive_enable),
        .wake_pin(wake_pin), .fault_pin_o(fault_pin_o),
        .fault_pin_oe(fault_pin_oe), .gate_bias_low(gate_bias_low),
        .mon_in(mon_in), .fault_msg_sent(fault_msg_sent),
        .gate_hi(gate_hi), .gate_lo(gate_lo), .block_en(block_en),
        .irq(irq)
    );
    gdsc_host host (
        .want_phase(want_phase), .want_float(want_float),
        .want_enable(want_enable), .fault_pin_o(fault_pin_o),
        .fault_pin_oe(fault_pin_oe), .phase_cmd(phase_cmd),
        .drive_enable(drive_enable), .fault_n(fault_n)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial
    begin
        forever #50 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] stat(input logic [5:0] l,
        input logic [1:0] s, input logic [2:0] p);
        return {18'h0, 1'b0, p, s, 1'b0, |l, l};
    endfunction

    // Expected block enables, ordered as the carrier struct.
    function automatic logic [31:0] exp_blk(input logic [1:0] s,
        input logic amp_off);
        case (s)
            2'h0: return 32'h1F;
            2'h1: return {26'h0, 2'b01, ~amp_off, 3'b101};
            2'h2: return 32'h20;
            default: return 32'h0;
        endcase
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One transfer; the request is held until pready is seen high.
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
    endtask

    task automatic gchk(input logic [5:0] c);
        chk("gate_hi", {29'h0, c[2:0]}, {29'h0, gate_hi});
        chk("gate_lo", {29'h0, c[5:3]}, {29'h0, gate_lo});
    endtask

    // Hang guard, well above the length of the sequence below.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        lf = 32'hF0BF;
        tick(2);
        presetn <= 1'b1;
        rchk("status_rst", ADDR_STATUS, '1, stat(0, 2'h1, PWR_POR));
        rchk("ctrl_rst", ADDR_CTRL, '1, {29'h0, CTRL_RESET});
        rchk("mask_rst", ADDR_IRQ_MASK, '1, 32'h0);
        rchk("unmapped", 8'h14, '1, 32'h0);
        chkb("slverr", 1'b1, err);
        chk("blk_stby", exp_blk(2'h1, 1'b0), {26'h0, block_en});
        wr(ADDR_PWR_CLR, 32'h0);
        want_enable <= 1'b1;
        tick(6);
        chk("blk_op", exp_blk(2'h0, 1'b0), {26'h0, block_en});
        for (int i = 0; i < 24; i++)
        begin
            lf = lfsr(lf);
            ph = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : lf[5:0];
            want_phase <= ph;
            want_float <= (i == 2);
            tick(4);
            gchk((i == 2) ? 6'h00 : ph);
        end
        want_phase <= 6'h07;
        tick(4);
        want_enable <= 1'b0;
        tick(DE_LOW - 6);
        gchk(6'h07);
        want_enable <= 1'b1;
        rchk("short_low", ADDR_STATUS, '1, stat(0, 2'h0, PWR_NORMAL));
        want_enable <= 1'b0;
        tick(DE_LOW + 6);
        gchk(6'h00);
        rchk("standby", ADDR_STATUS, '1, stat(0, 2'h1, PWR_NORMAL));
        chk("blk_amp", exp_blk(2'h1, 1'b0), {26'h0, block_en});
        wr(ADDR_CTRL, 32'h6);
        tick(3);
        chk("blk_noamp", exp_blk(2'h1, 1'b1), {26'h0, block_en});
        wr(ADDR_CTRL, 32'h2);
        want_enable <= 1'b1;
        gate_bias_low <= 6'h3F;
        want_phase <= 6'h00;
        tick(GB_FILTER_CYCLES + 50);
        rchk("bias_idle", ADDR_STATUS, '1, stat(0, 2'h0, PWR_NORMAL));
        wr(ADDR_CTRL, 32'h0);
        want_phase <= 6'h01;
        tick(GB_FILTER_CYCLES + 50);
        gchk(6'h01);
        rchk("bias_off", ADDR_STATUS, '1, stat(0, 2'h0, PWR_NORMAL));
        wr(ADDR_CTRL, 32'h2);
        tick(GB_FILTER_CYCLES + 20);
        gchk(6'h00);
        rchk("bias_flt", ADDR_STATUS, '1, stat(6'h10, 2'h0, PWR_NORMAL));
        chkb("fault_n", 1'b0, fault_n);
        rchk("istat", ADDR_IRQ_STAT, '1, 32'h5);
        chkb("irq_masked", 1'b0, irq);
        wr(ADDR_IRQ_MASK, 32'h1);
        tick(1);
        chkb("irq_on", 1'b1, irq);
        wr(ADDR_IRQ_STAT, 32'h1);
        tick(1);
        chkb("irq_clr", 1'b0, irq);
        want_phase <= 6'h38;
        tick(6);
        gchk(6'h00);
        gate_bias_low <= 6'h00;
        want_enable <= 1'b0;
        tick(5);
        want_enable <= 1'b1;
        tick(6);
        rchk("bias_clr", ADDR_STATUS, '1, stat(0, 2'h0, PWR_NORMAL));
        gchk(6'h38);
        chkb("fault_clr", 1'b1, fault_n);
        wr(ADDR_CTRL, 32'h3);
        want_enable <= 1'b0;
        tick(6);
        chk("blk_sleep", exp_blk(2'h2, 1'b0), {26'h0, block_en});
        gchk(6'h00);
        wake_pin <= 1'b1;
        tick(6);
        wake_pin <= 1'b0;
        rchk("wake", ADDR_STATUS, '1, stat(0, 2'h1, PWR_WAKE));
        rchk("ctrl_wake", ADDR_CTRL, '1, {29'h0, CTRL_RESET});
        wr(ADDR_PWR_CLR, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        mon_in.supply_cutoff <= 1'b1;
        tick(6);
        chk("blk_cut", exp_blk(2'h3, 1'b0), {26'h0, block_en});
        rchk("cut_state", ADDR_STATUS, 32'h300, 32'h300);
        mon_in.supply_cutoff <= 1'b0;
        tick(6);
        rchk("cut_pwr", ADDR_STATUS, '1, stat(0, 2'h1, PWR_CUTOFF));
        rchk("ctrl_cut", ADDR_CTRL, '1, {29'h0, CTRL_RESET});
        want_enable <= 1'b1;
        want_phase <= 6'h07;
        tick(6);
        mon_in.overtemp <= 1'b1;
        tick(6);
        gchk(6'h00);
        chkb("bias_reg", 1'b0, block_en.bias_reg);
        fault_msg_sent <= 1'b1;
        tick(1);
        fault_msg_sent <= 1'b0;
        tick(LINK_OFF - 10);
        chkb("link_early", 1'b1, block_en.link);
        tick(20);
        chkb("link_late", 1'b0, block_en.link);
        rchk("link_off", ADDR_STATUS, 32'h2000, 32'h2000);
        mon_in.overcurrent <= 1'b1;
        tick(4);
        mon_in.overcurrent <= 1'b0;
        tick(3);
        want_enable <= 1'b0;
        tick(5);
        want_enable <= 1'b1;
        tick(6);
        rchk("ot_kept", ADDR_STATUS, 32'h21, 32'h1);
        end_sim();
    end
endmodule
